// ### rtl/mie_pkg.sv
// Constants, register map and carrier types for the instruction execution core.
package mie_pkg;

	localparam int MIE_PC_W = 12;
	localparam int MIE_PAGE_W = MIE_PC_W - 8;
	localparam int MIE_TBL_DW = 16;

	// Register byte offsets on the Avalon-MM slave.
	localparam logic [5:0] MIE_OFS_CMD = 6'h00;
	localparam logic [5:0] MIE_OFS_STATUS = 6'h04;
	localparam logic [5:0] MIE_OFS_MEM_PTR = 6'h08;
	localparam logic [5:0] MIE_OFS_MEM_DATA = 6'h0C;
	localparam logic [5:0] MIE_OFS_PC = 6'h10;
	localparam logic [5:0] MIE_OFS_TBL_WR = 6'h14;
	localparam logic [5:0] MIE_OFS_TBL_CTRL = 6'h18;
	localparam logic [5:0] MIE_OFS_CORE = 6'h1C;
	localparam logic [5:0] MIE_OFS_WDT = 6'h20;

	localparam logic [3:0] MIE_BE_ALL = 4'hF;
	localparam logic [7:0] MIE_PCL_ADDR = 8'h06;
	localparam logic [3:0] MIE_NIB_LIMIT = 4'h9;
	localparam logic [7:0] MIE_DAA_LO = 8'h06;
	localparam logic [7:0] MIE_DAA_HI = 8'h60;
	localparam logic [7:0] MIE_BYTE_ZERO = 8'h00;
	localparam logic [7:0] MIE_BYTE_ONE = 8'h01;
	localparam logic [1:0] MIE_CYC_ONE = 2'h1;
	localparam logic [1:0] MIE_CYC_TWO = 2'h2;
	localparam logic [MIE_PC_W-1:0] MIE_PC_RST = 12'h000;
	localparam logic [MIE_PC_W-1:0] MIE_PC_STEP = 12'h001;
	localparam logic [MIE_PC_W-1:0] MIE_PC_SKIP = 12'h002;
	localparam logic [MIE_PAGE_W-1:0] MIE_LAST_PAGE = 4'hF;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_ADD_A_M = 5'h01, OP_ADD_TO_MEMORY = 5'h02,
		OP_ADD_LITERAL = 5'h03, OP_ADD_CARRY = 5'h04,
		OP_ADD_CARRY_TO_MEMORY = 5'h05, OP_AND_A_M = 5'h06,
		OP_AND_TO_MEMORY = 5'h07, OP_COMPLEMENT_IN_PLACE = 5'h08,
		OP_COMPLEMENT_TO_ACCUMULATOR = 5'h09, OP_DECIMAL_ADJUST = 5'h0A,
		OP_CLEAR_BYTE = 5'h0B, OP_CLEAR_BIT = 5'h0C, OP_SET_BIT = 5'h0D,
		OP_WATCHDOG_CLEAR = 5'h0E, OP_POWER_DOWN = 5'h0F,
		OP_MOVE_TO_ACCUMULATOR = 5'h10, OP_MOVE_TO_MEMORY = 5'h11,
		OP_LOAD_LITERAL = 5'h12, OP_UNCONDITIONAL_JUMP = 5'h13,
		OP_CALL = 5'h14, OP_RETURN = 5'h15, OP_RETURN_WITH_LITERAL = 5'h16,
		OP_ZERO_TEST_MOVE_SKIP = 5'h17,
		OP_DECREMENT_SKIP_TO_ACCUMULATOR = 5'h18, OP_INCREMENT_SKIP = 5'h19,
		OP_BIT_SET_SKIP = 5'h1A, OP_NIBBLE_SWAP_TO_ACCUMULATOR = 5'h1B,
		OP_TABLE_READ_PAGE = 5'h1C, OP_TABLE_READ_LAST_PAGE = 5'h1D
	} mie_op_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_EXEC = 4'b0010,
		ST_DUMMY = 4'b0100,
		ST_HALT = 4'b1000
	} mie_state_type;

	typedef struct packed {
		logic [MIE_PC_W-1:0] target;
		logic [7:0] operand;
		logic [2:0] bit_sel;
		mie_op_type op;
	} mie_cmd_type;

	typedef struct packed {
		logic ov;
		logic z;
		logic ac;
		logic c;
	} mie_flags_type;

	localparam int MIE_CMD_W = $bits(mie_cmd_type);
	localparam mie_flags_type MIE_FLAGS_RST = 4'h0;

endpackage : mie_pkg

// ### rtl/mie_core.sv
// Instruction execution core with an Avalon-MM command and register slave.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RL1] Skip instructions take two cycles when skipping, one otherwise.
// [RL2] Any write to the program counter low byte costs two cycles.
// [RL3] Call pushes PC plus one, loads target, two cycles, flags kept.
// [RL4] Return with literal pops PC, loads literal to accumulator, two cycles.
// [RL5] Table read fetches from given or current page to high byte and memory.
// [RL6] Last page table read fetches from the last page, two cycles.
// [RL7] Add with carry sums accumulator, operand, carry; updates four flags.
// [RL8] Add literal sums into accumulator and updates four flags.
// [RL9] And to memory writes the AND back to memory, zero flag only.
// [RL10] Clear byte writes zero to memory, no flag change.
// [RL11] Clear bit zeroes one selected bit, nothing else changes.
// [RL12] Watchdog clear resets counter, timeout flag and power down flag.
// [RL13] Complement inverts operand to memory or accumulator, zero flag only.
// [RL14] Decimal adjust adds six to low nibble above nine or on aux carry.
// [RL15] Decimal adjust adds six to high nibble above nine or on carry.
// [RL16] Decimal adjust changes no flag except carry.
// [RL17] Decimal adjust sets carry when it corrects the high nibble or the sum carries out.
// [RL18] Decrement skip puts operand minus one in accumulator, skips on zero.
// [RL19] Increment skip increments memory in place, skips on zero.
// [RL20] Zero test move copies operand to accumulator, skips on zero.
// [RL21] Bit set skip skips when the selected bit is one.
// [RL22] Nibble swap puts swapped operand in accumulator in one cycle.
// [RL23] Jump loads target in two cycles; literal load takes one.
// [RL24] Power down stops, clears watchdog, sets power down, clears timeout.
// [RL25] Zero flag is set exactly when the eight bit result is zero.
module mie_core #(
	parameter int DMEM_DEPTH = 64,
	parameter int STACK_DEPTH = 8,
	parameter int TBL_AW = 6,
	parameter int WDT_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic halted,
	output logic [7:0] accumulator_out,
	output mie_pkg::mie_flags_type flags_out
);
	import mie_pkg::*;

	localparam int DAW = $clog2(DMEM_DEPTH);
	localparam int SPW = $clog2(STACK_DEPTH);

	if (DMEM_DEPTH < 8 || DMEM_DEPTH > 256
		|| (1 << DAW) != DMEM_DEPTH) begin : g_chk_mem
		$error("DMEM_DEPTH must be a power of two from 8 to 256.");
	end
	if (STACK_DEPTH < 2 || (1 << SPW) != STACK_DEPTH) begin : g_chk_stack
		$error("STACK_DEPTH must be a power of two of at least 2.");
	end
	if (TBL_AW < 1 || TBL_AW > MIE_PC_W) begin : g_chk_tbl
		$error("TBL_AW must lie between 1 and the program counter width.");
	end
	if (WDT_W < 2 || WDT_W > 32) begin : g_chk_wdt
		$error("WDT_W must lie between 2 and 32.");
	end

	////////////////////////////////////////////////////////////////////////////

	function automatic logic [DAW-1:0] dm_index(input logic [7:0] a);
		dm_index = a[DAW-1:0];
	endfunction : dm_index

	// Returns {ov, ac, c, sum}; ov compares carries into and out of bit 7.
	function automatic logic [10:0] alu_add(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [8:0] s;
		logic [4:0] lo;
		logic [7:0] s7;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		s7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
		alu_add = {s7[7] ^ s[8], lo[4], s[8], s[7:0]};
	endfunction : alu_add

	function automatic mie_flags_type add_flags(input logic [10:0] r);
		add_flags = {r[10], r[7:0] == MIE_BYTE_ZERO, r[9], r[8]};
	endfunction : add_flags

	////////////////////////////////////////////////////////////////////////////

	mie_state_type state_reg, state_next;
	mie_cmd_type cmd_reg;
	mie_flags_type flags_reg, flags_d;
	logic [7:0] acc_reg;
	logic [7:0] mem_reg [DMEM_DEPTH];
	logic [MIE_PC_W-1:0] stack_reg [STACK_DEPTH];
	logic [SPW-1:0] sp_reg;
	logic [MIE_TBL_DW-1:0] tbl_reg [2**TBL_AW];
	logic [MIE_PC_W-1:0] pc_reg, pc_d;
	logic [7:0] mem_ptr_reg, tbl_ptr_reg, table_high_byte_reg;
	logic [MIE_PAGE_W-1:0] tbl_page_reg;
	logic tbl_use_page_reg;
	logic [WDT_W-1:0] watchdog_counter_reg;
	logic watchdog_timeout_flag_reg, power_down_flag_reg;
	logic [1:0] last_cycles_reg;
	logic last_skip_reg;
	logic rd_ack_reg;
	logic [31:0] readdata_reg;

	logic busy, wr_ok, cmd_wr, exec, timeout;
	logic [7:0] m_val, acc_d, mem_d, daa_adj;
	logic [10:0] sum;
	logic acc_we, mem_we, skip, two, push, pop, jump, table_high_byte_we, halt_op;
	logic wdt_clr, to_clr, pdf_clr, pdf_set;
	logic [MIE_PC_W-1:0] taddr;
	logic [MIE_TBL_DW-1:0] tword;

	assign busy = (state_reg == ST_EXEC) || (state_reg == ST_DUMMY);
	assign wr_ok = avs_write && !busy && (avs_byteenable == MIE_BE_ALL);
	assign cmd_wr = wr_ok && (avs_address == MIE_OFS_CMD);
	assign exec = (state_reg == ST_EXEC);
	// Writes stall while an instruction runs so bus and core never collide.
	assign avs_waitrequest = (avs_write && busy) || (avs_read && !rd_ack_reg);
	assign avs_readdata = readdata_reg;
	assign halted = (state_reg == ST_HALT);
	assign accumulator_out = acc_reg;
	assign flags_out = flags_reg;

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		m_val = (cmd_reg.operand == MIE_PCL_ADDR) ? pc_reg[7:0]
			: mem_reg[dm_index(cmd_reg.operand)];
		acc_d = acc_reg;
		mem_d = m_val;
		flags_d = flags_reg;
		acc_we = 1'b0;
		mem_we = 1'b0;
		skip = 1'b0;
		two = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		jump = 1'b0;
		table_high_byte_we = 1'b0;
		halt_op = 1'b0;
		wdt_clr = 1'b0;
		to_clr = 1'b0;
		pdf_clr = 1'b0;
		pdf_set = 1'b0;
		sum = '0;
		daa_adj = MIE_BYTE_ZERO;
		if (cmd_reg.op == OP_TABLE_READ_LAST_PAGE) begin
			taddr = {MIE_LAST_PAGE, tbl_ptr_reg}; // [RL6]
		end else if (tbl_use_page_reg) begin
			taddr = {tbl_page_reg, tbl_ptr_reg}; // [RL5]
		end else begin
			taddr = {pc_reg[MIE_PC_W-1:8], tbl_ptr_reg}; // [RL5]
		end
		tword = tbl_reg[taddr[TBL_AW-1:0]];
		case (cmd_reg.op)
			OP_ADD_A_M, OP_ADD_TO_MEMORY: begin
				sum = alu_add(acc_reg, m_val, 1'b0);
				flags_d = add_flags(sum); // [RL25]
				acc_we = (cmd_reg.op == OP_ADD_A_M);
				mem_we = !acc_we;
			end
			OP_ADD_LITERAL: begin
				sum = alu_add(acc_reg, cmd_reg.operand, 1'b0); // [RL8]
				flags_d = add_flags(sum); // [RL8]
				acc_we = 1'b1;
			end
			OP_ADD_CARRY, OP_ADD_CARRY_TO_MEMORY: begin
				sum = alu_add(acc_reg, m_val, flags_reg.c); // [RL7]
				flags_d = add_flags(sum); // [RL7]
				acc_we = (cmd_reg.op == OP_ADD_CARRY);
				mem_we = !acc_we; // [RL7]
			end
			OP_AND_A_M, OP_AND_TO_MEMORY: begin
				sum = {3'b000, acc_reg & m_val};
				flags_d.z = (sum[7:0] == MIE_BYTE_ZERO); // [RL9]
				acc_we = (cmd_reg.op == OP_AND_A_M);
				mem_we = !acc_we; // [RL9]
			end
			OP_COMPLEMENT_IN_PLACE, OP_COMPLEMENT_TO_ACCUMULATOR: begin
				sum = {3'b000, ~m_val}; // [RL13]
				flags_d.z = (sum[7:0] == MIE_BYTE_ZERO); // [RL25]
				acc_we = (cmd_reg.op == OP_COMPLEMENT_TO_ACCUMULATOR);
				mem_we = !acc_we; // [RL13]
			end
			OP_DECIMAL_ADJUST: begin
				if (acc_reg[3:0] > MIE_NIB_LIMIT || flags_reg.ac) begin
					daa_adj = daa_adj | MIE_DAA_LO; // [RL14]
				end
				if (acc_reg[7:4] > MIE_NIB_LIMIT || flags_reg.c) begin
					daa_adj = daa_adj | MIE_DAA_HI; // [RL15]
				end
				sum = alu_add(acc_reg, daa_adj, 1'b0);
				// Carry out of the correction means the sum passed 99.
				flags_d.c = flags_reg.c | daa_adj[5] | sum[8]; // [RL16] [RL17]
				mem_we = 1'b1; // [RL15]
			end
			OP_CLEAR_BYTE: begin
				sum = {3'b000, MIE_BYTE_ZERO}; // [RL10]
				mem_we = 1'b1;
			end
			OP_CLEAR_BIT: begin
				sum = {3'b000, m_val & ~(MIE_BYTE_ONE << cmd_reg.bit_sel)}; // [RL11]
				mem_we = 1'b1;
			end
			OP_SET_BIT: begin
				sum = {3'b000, m_val | (MIE_BYTE_ONE << cmd_reg.bit_sel)};
				mem_we = 1'b1;
			end
			OP_WATCHDOG_CLEAR: begin
				wdt_clr = 1'b1; // [RL12]
				to_clr = 1'b1;
				pdf_clr = 1'b1;
			end
			OP_POWER_DOWN: begin
				halt_op = 1'b1; // [RL24]
				wdt_clr = 1'b1;
				to_clr = 1'b1;
				pdf_set = 1'b1;
			end
			OP_MOVE_TO_ACCUMULATOR: begin
				sum = {3'b000, m_val};
				acc_we = 1'b1;
			end
			OP_MOVE_TO_MEMORY: begin
				sum = {3'b000, acc_reg};
				mem_we = 1'b1;
			end
			OP_LOAD_LITERAL: begin
				sum = {3'b000, cmd_reg.operand}; // [RL23]
				acc_we = 1'b1;
			end
			OP_UNCONDITIONAL_JUMP: begin
				jump = 1'b1; // [RL23]
			end
			OP_CALL: begin
				jump = 1'b1; // [RL3]
				push = 1'b1;
			end
			OP_RETURN: begin
				pop = 1'b1;
			end
			OP_RETURN_WITH_LITERAL: begin
				pop = 1'b1; // [RL4]
				sum = {3'b000, cmd_reg.operand};
				acc_we = 1'b1;
			end
			OP_ZERO_TEST_MOVE_SKIP: begin
				sum = {3'b000, m_val}; // [RL20]
				acc_we = 1'b1;
				skip = (m_val == MIE_BYTE_ZERO);
			end
			OP_DECREMENT_SKIP_TO_ACCUMULATOR: begin
				sum = {3'b000, m_val - MIE_BYTE_ONE}; // [RL18]
				acc_we = 1'b1;
				skip = (sum[7:0] == MIE_BYTE_ZERO);
			end
			OP_INCREMENT_SKIP: begin
				sum = {3'b000, m_val + MIE_BYTE_ONE}; // [RL19]
				mem_we = 1'b1;
				skip = (sum[7:0] == MIE_BYTE_ZERO);
			end
			OP_BIT_SET_SKIP: begin
				skip = m_val[cmd_reg.bit_sel]; // [RL21]
			end
			OP_NIBBLE_SWAP_TO_ACCUMULATOR: begin
				sum = {3'b000, m_val[3:0], m_val[7:4]}; // [RL22]
				acc_we = 1'b1;
			end
			OP_TABLE_READ_PAGE, OP_TABLE_READ_LAST_PAGE: begin
				sum = {3'b000, tword[7:0]}; // [RL5]
				mem_we = 1'b1;
				table_high_byte_we = 1'b1;
				two = 1'b1; // [RL6]
			end
			default: begin
			end
		endcase
		acc_d = sum[7:0];
		mem_d = sum[7:0];
		if (pop) begin
			pc_d = stack_reg[sp_reg - 1'b1];
		end else if (jump) begin
			pc_d = cmd_reg.target;
		end else if (skip) begin
			pc_d = pc_reg + MIE_PC_SKIP;
		end else begin
			pc_d = pc_reg + MIE_PC_STEP;
		end
		if (mem_we && cmd_reg.operand == MIE_PCL_ADDR) begin
			pc_d = {pc_reg[MIE_PC_W-1:8], mem_d}; // [RL2]
		end
		two = two | skip | jump | pop // [RL1] [RL3] [RL4] [RL23]
			| (mem_we && cmd_reg.operand == MIE_PCL_ADDR); // [RL2]
	end

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE, ST_HALT: begin
				if (cmd_wr) begin
					state_next = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (halt_op) begin
					state_next = ST_HALT; // [RL24]
				end else if (two) begin
					state_next = ST_DUMMY; // [RL1] [RL2]
				end else begin
					state_next = ST_IDLE;
				end
			end
			ST_DUMMY: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cmd_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (cmd_wr) begin
				cmd_reg <= mie_cmd_type'(avs_writedata[MIE_CMD_W-1:0]);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			last_cycles_reg <= MIE_CYC_ONE;
			last_skip_reg <= 1'b0;
		end else if (exec) begin
			last_cycles_reg <= two ? MIE_CYC_TWO : MIE_CYC_ONE; // [RL1]
			last_skip_reg <= skip;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			acc_reg <= MIE_BYTE_ZERO;
			flags_reg <= MIE_FLAGS_RST;
		end else if (exec) begin
			if (acc_we) begin
				acc_reg <= acc_d;
			end
			flags_reg <= flags_d;
		end else if (wr_ok && avs_address == MIE_OFS_CORE) begin
			acc_reg <= avs_writedata[7:0];
			flags_reg <= mie_flags_type'(avs_writedata[11:8]);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < DMEM_DEPTH; i++) begin
				mem_reg[i] <= MIE_BYTE_ZERO;
			end
		end else if (exec && mem_we && cmd_reg.operand != MIE_PCL_ADDR) begin
			mem_reg[dm_index(cmd_reg.operand)] <= mem_d;
		end else if (wr_ok && avs_address == MIE_OFS_MEM_DATA) begin
			mem_reg[dm_index(mem_ptr_reg)] <= avs_writedata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pc_reg <= MIE_PC_RST;
			sp_reg <= '0;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_reg[i] <= MIE_PC_RST;
			end
		end else if (exec) begin
			pc_reg <= pc_d;
			if (push) begin
				stack_reg[sp_reg] <= pc_reg + MIE_PC_STEP; // [RL3]
				sp_reg <= sp_reg + 1'b1;
			end else if (pop) begin
				sp_reg <= sp_reg - 1'b1; // [RL4]
			end
		end else if (wr_ok && avs_address == MIE_OFS_PC) begin
			pc_reg <= avs_writedata[MIE_PC_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			table_high_byte_reg <= MIE_BYTE_ZERO;
			mem_ptr_reg <= MIE_BYTE_ZERO;
			tbl_ptr_reg <= MIE_BYTE_ZERO;
			tbl_page_reg <= '0;
			tbl_use_page_reg <= 1'b0;
			for (int i = 0; i < 2**TBL_AW; i++) begin
				tbl_reg[i] <= '0;
			end
		end else begin
			if (exec && table_high_byte_we) begin
				table_high_byte_reg <= tword[15:8]; // [RL5] [RL6]
			end
			if (wr_ok && avs_address == MIE_OFS_MEM_PTR) begin
				mem_ptr_reg <= avs_writedata[7:0];
			end
			if (wr_ok && avs_address == MIE_OFS_TBL_CTRL) begin
				tbl_ptr_reg <= avs_writedata[7:0];
				tbl_page_reg <= avs_writedata[8+MIE_PAGE_W-1:8];
				tbl_use_page_reg <= avs_writedata[16];
			end
			if (wr_ok && avs_address == MIE_OFS_TBL_WR) begin
				tbl_reg[avs_writedata[16+TBL_AW-1:16]] <= avs_writedata[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////

	// The counter freezes in power down, standing in for the stopped clock.
	assign timeout = (&watchdog_counter_reg) && !halted;

	always_ff @(posedge clk) begin
		if (rst) begin
			watchdog_counter_reg <= '0;
		end else if (exec && wdt_clr) begin
			watchdog_counter_reg <= '0; // [RL12] [RL24]
		end else if (!halted) begin
			watchdog_counter_reg <= watchdog_counter_reg + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			watchdog_timeout_flag_reg <= 1'b0;
			power_down_flag_reg <= 1'b0;
		end else begin
			if (timeout) begin
				watchdog_timeout_flag_reg <= 1'b1;
			end else if (exec && to_clr) begin
				watchdog_timeout_flag_reg <= 1'b0; // [RL12] [RL24]
			end
			if (exec && pdf_set) begin
				power_down_flag_reg <= 1'b1; // [RL24]
			end else if (exec && pdf_clr) begin
				power_down_flag_reg <= 1'b0; // [RL12]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_ack_reg <= 1'b0;
			readdata_reg <= '0;
		end else begin
			rd_ack_reg <= avs_read && !rd_ack_reg;
			if (avs_read && !rd_ack_reg) begin
				case (avs_address)
					MIE_OFS_CMD: readdata_reg <= 32'(cmd_reg);
					MIE_OFS_STATUS: readdata_reg <= 32'({last_skip_reg,
						last_cycles_reg, busy, halted, power_down_flag_reg,
						watchdog_timeout_flag_reg, flags_reg, acc_reg});
					MIE_OFS_MEM_PTR: readdata_reg <= 32'(mem_ptr_reg);
					MIE_OFS_MEM_DATA: readdata_reg <= 32'(mem_reg[dm_index(mem_ptr_reg)]);
					MIE_OFS_PC: readdata_reg <= 32'(pc_reg);
					MIE_OFS_TBL_CTRL: readdata_reg <= 32'({tbl_use_page_reg,
						tbl_page_reg, tbl_ptr_reg});
					MIE_OFS_CORE: readdata_reg <= 32'({sp_reg, table_high_byte_reg});
					MIE_OFS_WDT: readdata_reg <= 32'(watchdog_counter_reg);
					default: readdata_reg <= '0;
				endcase
			end
		end
	end

endmodule : mie_core

`default_nettype wire

// ### tb/mie_checker.sv
// Concurrent checks on the ports of the instruction execution core.
`timescale 1ns/1ps
`default_nettype none
module mie_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic halted,
	input wire logic [7:0] accumulator_out,
	input wire mie_pkg::mie_flags_type flags_out
);
	import mie_pkg::*;
	logic cmd;
	mie_op_type op;
	assign cmd = avs_write && !avs_waitrequest && avs_address == MIE_OFS_CMD
		&& avs_byteenable == MIE_BE_ALL;
	assign op = mie_op_type'(avs_writedata[4:0]);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////
	AST_READ_WAIT: assert property ($rose(avs_read)
		|-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read answer not one cycle late");
	AST_HALT_WRITE: assert property (avs_write && halted |-> !avs_waitrequest)
		else $error("write stalled while halted");
	AST_SWAP_ONE: assert property (
		cmd && op == OP_NIBBLE_SWAP_TO_ACCUMULATOR ##2 avs_write
		|-> !avs_waitrequest) else $error("swap longer than one cycle");
	AST_JUMP_TWO: assert property (
		cmd && op == OP_UNCONDITIONAL_JUMP ##2 avs_write |-> avs_waitrequest)
		else $error("jump shorter than two cycles");
	AST_LITERAL: assert property (cmd && op == OP_LOAD_LITERAL
		|-> ##2 accumulator_out == $past(avs_writedata[15:8], 2))
		else $error("literal not loaded");
	AST_RET_LIT: assert property (cmd && op == OP_RETURN_WITH_LITERAL
		|-> ##3 accumulator_out == $past(avs_writedata[15:8], 3))
		else $error("return literal not loaded");
	AST_ADD_LIT: assert property (cmd && op == OP_ADD_LITERAL
		|-> ##2 accumulator_out == 8'($past(accumulator_out, 2)
		+ $past(avs_writedata[15:8], 2))) else $error("literal sum wrong");
	AST_ZERO: assert property (cmd && op == OP_ADD_LITERAL
		|-> ##2 flags_out.z == (accumulator_out == MIE_BYTE_ZERO))
		else $error("zero flag wrong");
	AST_CALL_FLAGS: assert property (cmd && op == OP_CALL
		|=> $stable(flags_out) [*3]) else $error("call changed flags");
	AST_CLEAR_KEEP: assert property (cmd && op == OP_CLEAR_BYTE
		|=> ($stable(flags_out) && $stable(accumulator_out)) [*2])
		else $error("clear changed flags");
	AST_DAA_FLAGS: assert property (cmd && op == OP_DECIMAL_ADJUST
		|-> ##2 flags_out[3:1] == $past(flags_out[3:1], 2)
		&& accumulator_out == $past(accumulator_out, 2))
		else $error("adjust changed other flags");
	AST_HALT: assert property (cmd && op == OP_POWER_DOWN |-> ##2 halted)
		else $error("power down did not halt");
	AST_WAKE: assert property (cmd && op == OP_WATCHDOG_CLEAR
		|-> ##2 !halted) else $error("still halted");
	////////////////////////////////////////////////////////////////////////////
	cover property (cmd && halted);
	cover property (cmd && op == OP_DECIMAL_ADJUST);
	cover property (cmd && op == OP_CALL);
endmodule : mie_checker
bind mie_core mie_checker mie_checker_i (.clk, .rst, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
	.avs_waitrequest, .halted, .accumulator_out, .flags_out);
`default_nettype wire

// ### tb/test_mcu_instruction_execution.sv
// Self-checking bench for the instruction execution core.
`timescale 1ns/1ps
`default_nettype none
module test_mcu_instruction_execution;
	import mie_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic [5:0] avs_address = '0;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = MIE_BE_ALL;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic halted;
	logic [7:0] accumulator_out;
	mie_flags_type flags_out;
	int err_count = 0;
	int samples_checked = 0;
	int seed = 1;
	logic [31:0] exq[$];
	logic [31:0] mq[$];
	logic [11:0] stk[$];
	logic [7:0] e_a, e_m, m;
	mie_flags_type e_f;
	logic [1:0] e_cy;
	logic e_sk;
	logic [11:0] e_pc;
	logic [31:0] st;
	logic [63:0] r;
	mie_op_type op;

	mie_core mie_core_i (.clk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.halted, .accumulator_out, .flags_out);

	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		// A read whose answer never came counts against the run.
		err_count += exq.size();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	// Waitrequest is read at the rising edge, before the slave updates it.
	task automatic bus(input logic [5:0] a, input logic rd,
		input logic [31:0] d);
		int n = 0;
		logic w = 1;
		@(posedge clk);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= d;
		while (w) begin
			@(posedge clk);
			w = avs_waitrequest;
			n++;
			if (n > 100) begin
				err_count++;
				final_report();
			end
		end
		avs_read <= 0;
		avs_write <= 0;
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(a, 1'b0, d);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [31:0] e,
		input logic [31:0] k);
		exq.push_back(e & k);
		mq.push_back(k);
		bus(a, 1'b1, '0);
	endtask : rd

	// The trailing pointer write stalls until the instruction has ended.
	task automatic ex(input mie_op_type o, input logic [2:0] b,
		input logic [7:0] x, input logic [11:0] t);
		wr(MIE_OFS_CMD, {4'h0, t, x, b, o});
		wr(MIE_OFS_MEM_PTR, 32'h10);
	endtask : ex

	always @(posedge clk) begin
		if (avs_read && !avs_waitrequest && exq.size() > 0) begin
			cmp(avs_readdata & mq.pop_front(), exq.pop_front());
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic model(input logic [7:0] a, input logic [7:0] x,
		input logic [2:0] b, input mie_flags_type f, input logic [11:0] p,
		input logic [11:0] t);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] v;
		logic ci;
		e_a = a;
		e_m = m;
		e_f = f;
		e_pc = p + 12'h1;
		case (op)
		OP_ADD_A_M, OP_ADD_TO_MEMORY, OP_ADD_LITERAL, OP_ADD_CARRY,
		OP_ADD_CARRY_TO_MEMORY: begin
			v = (op == OP_ADD_LITERAL) ? x : m;
			ci = op inside {OP_ADD_CARRY, OP_ADD_CARRY_TO_MEMORY} && f.c;
			s = a + v + ci;
			h = a[3:0] + v[3:0] + ci;
			e_f = '{ov: a[7] == v[7] && s[7] != a[7], z: s[7:0] == 8'h00,
				ac: h[4], c: s[8]};
			if (op inside {OP_ADD_TO_MEMORY, OP_ADD_CARRY_TO_MEMORY}) e_m = s[7:0];
			else e_a = s[7:0];
		end
		OP_DECIMAL_ADJUST: begin
			v = {(a[7:4] > 4'h9 || f.c) ? 4'h6 : 4'h0,
				(a[3:0] > 4'h9 || f.ac) ? 4'h6 : 4'h0};
			s = a + v;
			e_m = s[7:0];
			e_f.c = v[5] | s[8];
		end
		OP_AND_A_M: e_a = a & m;
		OP_AND_TO_MEMORY: e_m = a & m;
		OP_COMPLEMENT_IN_PLACE: e_m = ~m;
		OP_COMPLEMENT_TO_ACCUMULATOR: e_a = ~m;
		OP_CLEAR_BYTE: e_m = 8'h00;
		OP_CLEAR_BIT: e_m[b] = 1'b0;
		OP_SET_BIT: e_m[b] = 1'b1;
		OP_MOVE_TO_ACCUMULATOR, OP_ZERO_TEST_MOVE_SKIP: e_a = m;
		OP_MOVE_TO_MEMORY: e_m = a;
		OP_LOAD_LITERAL: e_a = x;
		OP_UNCONDITIONAL_JUMP: e_pc = t;
		OP_CALL: begin
			stk.push_back(e_pc);
			e_pc = t;
		end
		OP_RETURN_WITH_LITERAL: begin
			e_pc = stk.pop_back();
			e_a = x;
		end
		OP_DECREMENT_SKIP_TO_ACCUMULATOR: e_a = m - 8'h01;
		OP_INCREMENT_SKIP: e_m = m + 8'h01;
		OP_NIBBLE_SWAP_TO_ACCUMULATOR: e_a = {m[3:0], m[7:4]};
		default: ;
		endcase
		if (op inside {OP_AND_A_M, OP_COMPLEMENT_TO_ACCUMULATOR}) e_f.z = !e_a;
		if (op inside {OP_AND_TO_MEMORY, OP_COMPLEMENT_IN_PLACE}) e_f.z = !e_m;
		e_sk = op == OP_ZERO_TEST_MOVE_SKIP ? m == 8'h00
			: op == OP_DECREMENT_SKIP_TO_ACCUMULATOR ? e_a == 8'h00
			: op == OP_INCREMENT_SKIP ? e_m == 8'h00
			: op == OP_BIT_SET_SKIP ? m[b] : 1'b0;
		if (e_sk) e_pc = p + 12'h2;
		e_cy = (e_sk || op inside {OP_UNCONDITIONAL_JUMP, OP_CALL,
			OP_RETURN_WITH_LITERAL}) ? 2'h2 : 2'h1;
	endtask : model
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		rd(MIE_OFS_STATUS, 32'h1_0000, 32'hFFFF_FFFF);
		wr(MIE_OFS_MEM_PTR, 32'h10);
		// Fixed zero, all-ones and one operands first, so every skip is hit.
		for (int i = 0; i < 6; i++) begin
			for (int k = 1; k < 28; k++) begin
				if (k == 14 || k == 15 || k == 21) continue;
				op = mie_op_type'(k);
				r = {$random(seed), $random(seed)};
				m = i == 0 ? 8'h00 : i == 1 ? 8'hFF : i == 2 ? 8'h01 : r[55:48];
				wr(MIE_OFS_MEM_DATA, {24'h0, m});
				wr(MIE_OFS_CORE, {20'h0, r[19:16], r[7:0]});
				wr(MIE_OFS_PC, {20'h0, r[34:23]});
				model(r[7:0], r[15:8], r[22:20], r[19:16], r[34:23], r[46:35]);
				ex(op, r[22:20], op inside {OP_ADD_LITERAL, OP_LOAD_LITERAL,
					OP_RETURN_WITH_LITERAL} ? r[15:8] : 8'h10, r[46:35]);
				st = {13'h0, e_sk, e_cy, 4'h0, e_f, e_a};
				rd(MIE_OFS_MEM_DATA, {24'h0, e_m}, 32'hFF);
				rd(MIE_OFS_MEM_DATA, {24'h0, e_m}, 32'hFF);
				rd(MIE_OFS_STATUS, st, 32'h7_0000);
				rd(MIE_OFS_STATUS, st, 32'h8FFF);
				rd(MIE_OFS_STATUS, st, 32'h7_8FFF);
				rd(MIE_OFS_PC, {20'h0, e_pc}, 32'hFFF);
			end
		end
		wr(MIE_OFS_PC, 32'h1AB);
		ex(OP_CLEAR_BYTE, 3'h0, MIE_PCL_ADDR, 12'h0);
		rd(MIE_OFS_PC, 32'h100, 32'hFFF);
		rd(MIE_OFS_STATUS, 32'h2_0000, 32'h3_0000);
		wr(MIE_OFS_TBL_WR, 32'h0005_A55A);
		wr(MIE_OFS_TBL_CTRL, 32'h0001_0305);
		for (int k = 0; k < 2; k++) begin
			wr(MIE_OFS_MEM_DATA, 32'h0);
			ex(k ? OP_TABLE_READ_LAST_PAGE : OP_TABLE_READ_PAGE, 3'h0, 8'h10, 12'h0);
			rd(MIE_OFS_MEM_DATA, 32'h5A, 32'hFF);
			rd(MIE_OFS_CORE, 32'hA5, 32'hFF);
			rd(MIE_OFS_STATUS, 32'h2_0000, 32'h3_0000);
		end
		ex(OP_POWER_DOWN, 3'h0, 8'h10, 12'h0);
		rd(MIE_OFS_STATUS, 32'h6000, 32'h7000);
		rd(MIE_OFS_WDT, 32'h0, 32'hFFFF);
		ex(OP_WATCHDOG_CLEAR, 3'h0, 8'h10, 12'h0);
		rd(MIE_OFS_STATUS, 32'h0, 32'h7000);
		// A partial-width write must leave the byte alone.
		avs_byteenable <= 4'h3;
		wr(MIE_OFS_MEM_DATA, 32'h77);
		avs_byteenable <= MIE_BE_ALL;
		rd(MIE_OFS_MEM_DATA, 32'h5A, 32'hFF);
		rd(6'h24, 32'h0, 32'hFFFF_FFFF);
		// Let the watcher take the last answer before the verdict.
		@(posedge clk);
		final_report();
	end
endmodule : test_mcu_instruction_execution
`default_nettype wire
